// >>> cbh_block.v
// Command block handshake engine with transmit FIFO, adapter side
`include "cbh_consts.vh"

// ----------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------
module cbh_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   clock,
   rst,
   flush,
   in_valid,
   in_ready,
   in_data,
   out_valid,
   out_ready,
   out_data
);
   input wire clock;
   input wire rst;
   input wire flush;
   input wire in_valid;
   output wire in_ready;
   input wire [WIDTH-1:0] in_data;
   output wire out_valid;
   input wire out_ready;
   output wire [WIDTH-1:0] out_data;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   // Depth as a counter-wide constant, so the full compare keeps its width
   localparam [AW:0] FULL_CNT = DEPTH;
   wire push;
   wire pop;

   assign in_ready = (cnt_q != FULL_CNT);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clock) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else if (flush) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // cbh_fifo

// ----------------------------------------------------------------
// Handshake engine
// ----------------------------------------------------------------
module cbh_block #(
   parameter FIRST_TMO = `CBH_FIRST_TMO_CYC,
   parameter BYTE_TMO = `CBH_BYTE_TMO_CYC,
   parameter ACK_TMO = `CBH_ACK_TMO_CYC
) (
   clock,
   rst,
   host_wr,
   host_data,
   host_flag_low,
   host_flag_high,
   host_rd,
   cmd_reg,
   host_cmdreg_full,
   adapter_cmdreg_empty,
   adapter_flag_low,
   adapter_flag_high,
   host_irq,
   adapter_irq,
   rx_verdict_valid,
   rx_verdict_accept,
   rx_done,
   rx_bad,
   rx_cmd,
   rx_len,
   rx_rd_index,
   rx_rd_data,
   tx_valid,
   tx_ready,
   tx_data,
   tx_last,
   tx_busy,
   tx_done,
   tx_accepted,
   tx_timeout
);
   input wire clock;
   input wire rst;
   input wire host_wr;
   input wire [7:0] host_data;
   input wire host_flag_low;
   input wire host_flag_high;
   input wire host_rd;
   output reg [7:0] cmd_reg;
   output reg host_cmdreg_full;
   output reg adapter_cmdreg_empty;
   output wire adapter_flag_low;
   output wire adapter_flag_high;
   output reg host_irq;
   output reg adapter_irq;
   input wire rx_verdict_valid;
   input wire rx_verdict_accept;
   output reg rx_done;
   output reg rx_bad;
   output reg [7:0] rx_cmd;
   output reg [7:0] rx_len;
   input wire [5:0] rx_rd_index;
   output reg [7:0] rx_rd_data;
   input wire tx_valid;
   output wire tx_ready;
   input wire [7:0] tx_data;
   input wire tx_last;
   output wire tx_busy;
   output reg tx_done;
   output reg tx_accepted;
   output reg tx_timeout;

   localparam S_IDLE = 3'd0;
   localparam S_FIRST = 3'd1;
   localparam S_BYTE = 3'd2;
   localparam S_LEN = 3'd3;
   localparam S_ACK = 3'd4;
   localparam S_RXV = 3'd5;

   // Host pins are asynchronous: two flops before use
   reg [1:0] hwr_s1_q;
   reg [1:0] hwr_s2_q;
   reg [1:0] hfl_s1_q;
   reg [1:0] hfl_s2_q;
   reg hrd_s1_q;
   reg hrd_s2_q;
   reg hwr_old_q;
   reg hrd_old_q;
   reg [7:0] hdat_s1_q;
   reg [7:0] hdat_s2_q;
   wire hwr_pulse;
   wire hrd_pulse;
   wire [1:0] hflags;

   reg [7:0] ring [0:`CBH_BUF_DEPTH-1];
   reg [5:0] ring_wp_q;
   reg [6:0] rx_cnt_q;
   reg rx_active_q;
   reg [2:0] st_q;
   reg [1:0] aflag_q;
   reg [31:0] tmo_q;
   reg [6:0] tx_cnt_q;
   reg len_pending_q;
   wire fifo_valid;
   wire [8:0] fifo_data;
   wire fifo_pop;

   function is_request;
      input [7:0] code;
      begin
         is_request = (code >= `CBH_REQ_FIRST) && (code <= `CBH_REQ_LAST);
      end
   endfunction

   assign hwr_pulse = hwr_s2_q[0] & ~hwr_old_q;
   assign hrd_pulse = hrd_s2_q & ~hrd_old_q;
   assign hflags = hfl_s2_q;
   assign adapter_flag_low = aflag_q[0];
   assign adapter_flag_high = aflag_q[1];
   assign tx_busy = (st_q != S_IDLE) && (st_q != S_RXV);
   assign fifo_pop = fifo_valid && adapter_cmdreg_empty && !len_pending_q &&
      ((st_q == S_IDLE && !rx_active_q) || st_q == S_BYTE);

   cbh_fifo #(.WIDTH(9), .DEPTH(8), .AW(3)) u_fifo (
      .clock(clock),
      .rst(rst),
      .flush(tx_timeout),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data({tx_last, tx_data}),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         hwr_s1_q <= 2'b00;
         hwr_s2_q <= 2'b00;
         hfl_s1_q <= 2'b00;
         hfl_s2_q <= 2'b00;
         hrd_s1_q <= 1'b0;
         hrd_s2_q <= 1'b0;
         hwr_old_q <= 1'b0;
         hrd_old_q <= 1'b0;
         hdat_s1_q <= 8'h00;
         hdat_s2_q <= 8'h00;
      end else begin
         hwr_s1_q <= {1'b0, host_wr};
         hwr_s2_q <= hwr_s1_q;
         hfl_s1_q <= {host_flag_high, host_flag_low};
         hfl_s2_q <= hfl_s1_q;
         hrd_s1_q <= host_rd;
         hrd_s2_q <= hrd_s1_q;
         hwr_old_q <= hwr_s2_q[0];
         hrd_old_q <= hrd_s2_q;
         hdat_s1_q <= host_data;
         hdat_s2_q <= hdat_s1_q;
      end
   end

   always @(posedge clock) begin
      if (hwr_pulse) begin
         ring[ring_wp_q] <= hdat_s2_q;
      end
      rx_rd_data <= ring[rx_rd_index];
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ring_wp_q <= 6'd0;
         rx_cnt_q <= 7'd0;
         rx_active_q <= 1'b0;
         host_cmdreg_full <= 1'b0;
         adapter_irq <= 1'b0;
         rx_done <= 1'b0;
         rx_bad <= 1'b0;
         rx_cmd <= 8'h00;
         rx_len <= 8'h00;
         st_q <= S_IDLE;
         aflag_q <= `CBH_FLAG_NONE;
         tmo_q <= 32'd0;
         tx_cnt_q <= 7'd0;
         len_pending_q <= 1'b0;
         cmd_reg <= 8'h00;
         adapter_cmdreg_empty <= 1'b1;
         host_irq <= 1'b0;
         tx_done <= 1'b0;
         tx_accepted <= 1'b0;
         tx_timeout <= 1'b0;
      end else begin
         adapter_irq <= 1'b0;
         host_irq <= 1'b0;
         rx_done <= 1'b0;
         tx_done <= 1'b0;
         tx_timeout <= 1'b0;
         host_cmdreg_full <= 1'b0;
         // Receive path runs at any time; the adapter never refuses to read
         if (hwr_pulse) begin
            ring_wp_q <= ring_wp_q + 6'd1;
            host_cmdreg_full <= 1'b1;
            if (!rx_active_q) begin
               adapter_irq <= 1'b1;
               rx_active_q <= 1'b1;
               rx_cnt_q <= 7'd1;
            end else begin
               rx_cnt_q <= rx_cnt_q + 7'd1;
            end
            if (hflags == `CBH_FLAG_END) begin
               // Length byte marks block start; stray prefix bytes are dropped
               rx_active_q <= 1'b0;
               rx_done <= 1'b1;
               rx_cmd <= ring[ring_wp_q - hdat_s2_q[5:0]];
               rx_len <= ring[ring_wp_q - hdat_s2_q[5:0] + 6'd1];
               rx_bad <= (hdat_s2_q > 8'd64) ||
                  !is_request(ring[ring_wp_q - hdat_s2_q[5:0]]) ||
                  (ring[ring_wp_q - hdat_s2_q[5:0] + 6'd1] > `CBH_MAX_DATA) ||
                  (ring[ring_wp_q - hdat_s2_q[5:0] + 6'd1] + 8'd2 != hdat_s2_q);
               st_q <= (st_q == S_IDLE) ? S_RXV : st_q;
               tmo_q <= 32'd0;
            end
         end
         if (hrd_pulse) begin
            adapter_cmdreg_empty <= 1'b1;
         end
         case (st_q)
            S_IDLE: begin
               if (fifo_pop) begin
                  cmd_reg <= fifo_data[7:0];
                  adapter_cmdreg_empty <= 1'b0;
                  host_irq <= 1'b1;
                  tx_cnt_q <= 7'd1;
                  len_pending_q <= fifo_data[8];
                  aflag_q <= `CBH_FLAG_NONE;
                  tmo_q <= 32'd0;
                  st_q <= S_FIRST;
               end
            end
            S_FIRST, S_BYTE: begin
               if (len_pending_q && adapter_cmdreg_empty) begin
                  aflag_q <= `CBH_FLAG_END;
                  st_q <= S_LEN;
                  tmo_q <= 32'd0;
               end else if (fifo_pop) begin
                  cmd_reg <= fifo_data[7:0];
                  adapter_cmdreg_empty <= 1'b0;
                  tx_cnt_q <= tx_cnt_q + 7'd1;
                  len_pending_q <= fifo_data[8];
                  tmo_q <= 32'd0;
               end else if (!adapter_cmdreg_empty) begin
                  tmo_q <= tmo_q + 32'd1;
                  if (tmo_q >= ((st_q == S_FIRST) ? FIRST_TMO : BYTE_TMO) - 1) begin
                     st_q <= S_IDLE;
                     aflag_q <= `CBH_FLAG_NONE;
                     adapter_cmdreg_empty <= 1'b1;
                     len_pending_q <= 1'b0;
                     tx_timeout <= 1'b1;
                  end
               end else begin
                  if (st_q == S_FIRST) begin
                     st_q <= S_BYTE;
                  end
                  tmo_q <= 32'd0;
               end
            end
            S_LEN: begin
               // Flags stand one cycle before the length byte appears
               cmd_reg <= {1'b0, tx_cnt_q};
               adapter_cmdreg_empty <= 1'b0;
               len_pending_q <= 1'b0;
               tmo_q <= 32'd0;
               st_q <= S_ACK;
            end
            S_ACK: begin
               if (hflags == `CBH_FLAG_ACCEPT || hflags == `CBH_FLAG_REJECT) begin
                  tx_done <= 1'b1;
                  tx_accepted <= (hflags == `CBH_FLAG_ACCEPT);
                  aflag_q <= `CBH_FLAG_NONE;
                  st_q <= S_IDLE;
               end else begin
                  tmo_q <= tmo_q + 32'd1;
                  if (tmo_q >= ACK_TMO - 1) begin
                     tx_timeout <= 1'b1;
                     aflag_q <= `CBH_FLAG_NONE;
                     st_q <= S_IDLE;
                  end
               end
            end
            S_RXV: begin
               if (rx_verdict_valid) begin
                  aflag_q <= rx_verdict_accept ? `CBH_FLAG_ACCEPT : `CBH_FLAG_REJECT;
                  st_q <= S_IDLE;
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // cbh_block

// >>> cbh_consts.vh
// Constants for the command block handshake block
`ifndef CBH_CONSTS_VH
`define CBH_CONSTS_VH
// ----------------------------------------------------------------
// Flag states
// ----------------------------------------------------------------
`define CBH_FLAG_NONE 2'b00
`define CBH_FLAG_ACCEPT 2'b01
`define CBH_FLAG_REJECT 2'b10
`define CBH_FLAG_END 2'b11
// ----------------------------------------------------------------
// Block layout and codes
// ----------------------------------------------------------------
`define CBH_BUF_DEPTH 64
`define CBH_MAX_DATA 8'h3e
`define CBH_REQ_FIRST 8'h01
`define CBH_REQ_LAST 8'h11
`define CBH_RSP_OFFSET 8'h30
`define CBH_RSP_FIRST 8'h31
`define CBH_RSP_LAST 8'h41
`define CBH_CMD_DMA_DOWN 8'h04
`define CBH_CMD_DMA_UP 8'h05
`define CBH_CMD_PIO_DOWN 8'h06
`define CBH_CMD_PIO_UP 8'h07
`define CBH_CMD_RX_PKT 8'h08
`define CBH_CMD_TX_PKT 8'h09
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CBH_CLK_MHZ 40
`define CBH_FIRST_TMO_US 20000
`define CBH_BYTE_TMO_US 500
`define CBH_ACK_TMO_US 50000
`define CBH_FIRST_TMO_CYC (`CBH_FIRST_TMO_US * `CBH_CLK_MHZ)
`define CBH_BYTE_TMO_CYC (`CBH_BYTE_TMO_US * `CBH_CLK_MHZ)
`define CBH_ACK_TMO_CYC (`CBH_ACK_TMO_US * `CBH_CLK_MHZ)
`endif

// >>> cbh_chk_assertions.sv
// Port-level assertions for the handshake engine
module cbh_chk #(
   parameter FIRST_TMO = 50
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic host_flag_low,
   input wire logic host_flag_high,
   input wire logic adapter_cmdreg_empty,
   input wire logic adapter_flag_low,
   input wire logic adapter_flag_high,
   input wire logic host_irq,
   input wire logic rx_verdict_valid,
   input wire logic rx_verdict_accept,
   input wire logic rx_done,
   input wire logic tx_busy,
   input wire logic tx_done,
   input wire logic tx_accepted,
   input wire logic tx_timeout
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   wire [1:0] af = {adapter_flag_high, adapter_flag_low};
   wire [1:0] hf = {host_flag_high, host_flag_low};
   int stuck_q;
   // An unread byte must be given up on, however slow the host is
   always_ff @(posedge clock or posedge rst) begin
      if (rst) stuck_q <= 0;
      else if (tx_busy && !adapter_cmdreg_empty) stuck_q <= stuck_q + 1;
      else stuck_q <= 0;
   end
   a_rx_end: assert property (rx_done |-> hf == 2'b11)
      else $error("rx end flags");
   a_acc_flag: assert property (rx_verdict_valid && rx_verdict_accept |-> ##[1:3] af == 2'b01)
      else $error("accept flags");
   a_rej_flag: assert property (rx_verdict_valid && !rx_verdict_accept |-> ##[1:3] af == 2'b10)
      else $error("reject flags");
   a_len_end: assert property ($rose(af == 2'b11) |-> adapter_cmdreg_empty ##1 !adapter_cmdreg_empty)
      else $error("length byte order");
   a_irq_byte: assert property (host_irq |-> ##[0:1] !adapter_cmdreg_empty)
      else $error("irq without byte");
   a_wait_bound: assert property (stuck_q <= FIRST_TMO + 4)
      else $error("empty wait too long");
   a_tmo_clear: assert property (tx_timeout |-> ##[0:1] af == 2'b00)
      else $error("timeout flags");
   a_done_verdict: assert property (tx_done |-> hf == (tx_accepted ? 2'b01 : 2'b10))
      else $error("done verdict");
   a_done_clear: assert property (tx_done |-> ##[0:1] af == 2'b00)
      else $error("done flags");
   c_rx: cover property (rx_done);
   c_acc: cover property (tx_done && tx_accepted);
   c_tmo: cover property (tx_timeout);
endmodule // cbh_chk
bind cbh_block cbh_chk #(.FIRST_TMO(FIRST_TMO)) cbh_chk_i (.*);

// >>> cbh_host_model.sv
// Host driver model: reads adapter blocks and answers them
module cbh_host (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] cmd_reg,
   input wire logic adapter_cmdreg_empty,
   input wire logic adapter_flag_low,
   input wire logic adapter_flag_high,
   input wire logic tx_done,
   input wire logic [1:0] tb_flags,
   input wire logic acc,
   input wire logic [7:0] vdelay,
   input wire logic [7:0] budget,
   output logic host_rd,
   output logic host_flag_low,
   output logic host_flag_high
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got [$];
   logic [7:0] nrd;
   logic [1:0] vf;
   logic va;
   logic eob;
   int seed;
   assign {host_flag_high, host_flag_low} = va ? vf : tb_flags;
   // Negedge timing keeps sampling clear of the design's own edge
   initial begin
      host_rd = 0;
      va = 0;
      vf = 0;
      nrd = 0;
      seed = 3;
      forever begin
         @(negedge clock);
         if (!rst && !adapter_cmdreg_empty && nrd < budget) begin
            repeat ($unsigned($random(seed)) % 6) @(negedge clock);
            eob = adapter_flag_low & adapter_flag_high;
            got.push_back(cmd_reg);
            nrd++;
            host_rd <= 1;
            for (int i = 0; i < 12 && !adapter_cmdreg_empty; i++) @(negedge clock);
            host_rd <= 0;
            if (eob) begin
               vf <= acc ? 2'b01 : 2'b10;
               repeat (vdelay) @(negedge clock);
               va <= 1;
               for (int i = 0; i < 20 && !tx_done; i++) @(negedge clock);
               repeat (4) @(negedge clock);
               va <= 0;
            end
         end
      end
   end
endmodule // cbh_host

// >>> cbh_block_tb.sv
// Self-checking bench for the handshake engine
module cbh_block_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
   logic clock = 0;
   logic rst = 1;
   logic host_wr = 0;
   logic rx_verdict_valid = 0;
   logic rx_verdict_accept = 0;
   logic tx_valid = 0;
   logic tx_last = 0;
   logic acc = 1;
   logic [7:0] host_data = 0, tx_data = 0, vdelay = 3, budget = 8'hff;
   logic [5:0] rx_rd_index = 0;
   logic [1:0] tb_flags = 0;
   wire [7:0] cmd_reg, rx_cmd, rx_len, rx_rd_data;
   wire host_rd, host_flag_low, host_flag_high, host_cmdreg_full, adapter_cmdreg_empty;
   wire adapter_flag_low, adapter_flag_high, host_irq, adapter_irq, rx_done, rx_bad;
   wire tx_ready, tx_busy, tx_done, tx_accepted, tx_timeout;
   int error_cnt = 0, n_checks = 0, seed = 32'h5a32266a, wp = 0, rxn = 0, txn = 0, tmo = 0;
   int fulln = 0, irqn = 0;
   int k, ok;
   logic [7:0] ring [64];
   logic [7:0] exq [$];
   logic [7:0] rxc, rxl;
   logic rxb, txa;
   cbh_block #(.FIRST_TMO(50), .BYTE_TMO(20), .ACK_TMO(100)) cbh_block_i (.*);
   cbh_host cbh_host_i (.*);
   initial begin
      forever #12.5 clock = ~clock;
   end
   always @(negedge clock) begin
      if (rx_done === 1'b1) begin
         rxn++;
         rxc = rx_cmd;
         rxl = rx_len;
         rxb = rx_bad;
      end
      if (tx_done === 1'b1) begin
         txn++;
         txa = tx_accepted;
      end
      if (tx_timeout === 1'b1) tmo++;
      if (host_cmdreg_full === 1'b1) fulln++;
      if (adapter_irq === 1'b1) irqn++;
   end
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic waitfor(ref int c, input int v, input int lim);
      for (int i = 0; i < lim && c < v; i++) @(negedge clock);
      if (c < v) begin
         error_cnt++;
         $display("[ERR] wait exp %0d got %0d", v, c);
         end_sim;
      end
   endtask
   // ----
   // Host side of the command register
   // ----
   task hwr(input [7:0] b, input st);
      @(posedge clock) host_data <= b;
      repeat (4) @(posedge clock);
      host_wr <= 1;
      repeat (4) @(posedge clock);
      host_wr <= 0;
      host_data <= ~b;
      repeat (3) @(posedge clock);
      if (st) begin
         ring[wp % 64] = b;
         wp++;
      end
   endtask
   task automatic hblk(input [7:0] c, input [7:0] n, input [7:0] tot, input a);
      int r0 = rxn;
      logic [5:0] ix;
      logic [7:0] ec, el;
      hwr(c, 1);
      hwr(n, 1);
      repeat (n) hwr(8'($random(seed)), 1);
      `CHK("rx_early", r0, rxn)
      // Block start as the length byte will locate it in the ring
      ix = 6'(wp - tot);
      ec = ring[ix];
      el = ring[6'(ix + 6'd1)];
      tb_flags <= 2'b11;
      hwr(tot, 1);
      waitfor(rxn, r0 + 1, 30);
      `CHK("rx_cmd", ec, rxc)
      `CHK("rx_len", el, rxl)
      `CHK("rx_bad", 1'(tot > 64 || ec == 0 || ec > 8'h11 || el > 8'h3e || el + 8'd2 != tot), rxb)
      `CHK("cmdreg_full", wp, fulln)
      @(posedge clock) rx_rd_index <= ix;
      repeat (2) @(negedge clock);
      `CHK("ring", ring[ix], rx_rd_data)
      @(posedge clock) rx_verdict_valid <= 1;
      rx_verdict_accept <= a;
      @(posedge clock) rx_verdict_valid <= 0;
      repeat (3) @(negedge clock);
      `CHK("a_flags", a ? 2'b01 : 2'b10, {adapter_flag_high, adapter_flag_low})
      @(posedge clock) tb_flags <= 2'b00;
   endtask
   // ----
   // Adapter send side
   // ----
   task automatic push(input [7:0] b, input l, output int ok);
      @(posedge clock) tx_valid <= 1;
      tx_data <= b;
      tx_last <= l;
      ok = 0;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(negedge clock);
         ok = tx_ready;
      end
      @(posedge clock) tx_valid <= 0;
   endtask
   task automatic tblk(input [7:0] c, input int n, input a, input [7:0] bud, input [7:0] vd);
      int t0 = txn;
      int m0 = tmo;
      int r;
      cbh_host_i.got.delete();
      exq.delete();
      acc <= a;
      vdelay <= vd;
      budget <= (bud == 8'hff) ? bud : cbh_host_i.nrd + bud;
      exq.push_back(c);
      if (n >= 0) exq.push_back(8'(n));
      for (int i = 0; i < n; i++) exq.push_back(8'($random(seed)));
      foreach (exq[i]) push(exq[i], i == exq.size() - 1, r);
      exq.push_back(8'(exq.size()));
      if (bud < exq.size() || vd > 100) begin
         waitfor(tmo, m0 + 1, 400);
         @(negedge clock);
         `CHK("tmo_flags", 2'b00, {adapter_flag_high, adapter_flag_low})
         // Let a late host answer die out before the next block
         repeat (90) @(posedge clock);
      end else begin
         waitfor(txn, t0 + 1, 900);
         `CHK("tx_acc", a, txa)
         `CHK("tx_cnt", exq.size(), cbh_host_i.got.size())
         foreach (exq[i]) `CHK("tx_byte", exq[i], cbh_host_i.got[i])
      end
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst <= 0;
      for (k = 0; k < 19; k++) hblk(k == 18 ? 8'h2f : 8'(k + 1), 8'(k % 3), 8'(k % 3 + 2), k < 17 && k[0]);
      $display("test codes done");
      `CHK("irq", 19, irqn)
      repeat (3) hwr(8'($random(seed)), 1);
      `CHK("stray", 19, rxn)
      hblk(8'h09, 8'd62, 8'd64, 1);
      hblk(8'h01, 8'd0, 8'h45, 0);
      $display("test stray and length done");
      for (k = 0; k < 3; k++) tblk(8'h31 + 8'(k * 8), k * 5, k[0], 8'hff, 8'd3);
      tblk(8'h41, -1, 1, 8'hff, 8'd3);
      $display("test send done");
      tblk(8'h34, 2, 1, 8'd0, 8'd3);
      tblk(8'h38, 3, 1, 8'd2, 8'd3);
      tblk(8'h3a, 1, 1, 8'hff, 8'd150);
      $display("test timeouts done");
      budget <= cbh_host_i.nrd;
      k = 0;
      ok = 1;
      while (ok && k < 12) begin
         push(8'($random(seed)), 0, ok);
         k += ok;
      end
      `CHK("fill", 1'b1, 1'(k >= 8 && k <= 10))
      k = tmo;
      waitfor(tmo, k + 1, 200);
      @(negedge clock);
      `CHK("flush", 1'b1, tx_ready)
      $display("test buffer done");
      end_sim;
   end
endmodule // cbh_block_tb
